// [core/mmd_pkg.sv]
// Package of field codes, register offsets and reset values for the micro memory and flag decoder.
package mmd_pkg;

	// ----------------------------------------------------------------
	// Cycle control and test enable codes
	// ----------------------------------------------------------------
	localparam logic [1:0] CC_NONE = 2'h0; // No memory cycle; flag and special codes apply.
	localparam logic [1:0] CC_UNCOND = 2'h1; // Unconditional start or override.
	localparam logic [1:0] CC_ON_FALSE = 2'h2; // Unconditional when not testing, else on false.
	localparam logic [1:0] CC_ON_TRUE = 2'h3; // Start or override on a true condition.
	localparam logic [1:0] TE_NONE = 2'h0; // No test selected.

	// ----------------------------------------------------------------
	// Operation select codes and field positions
	// ----------------------------------------------------------------
	localparam logic [1:0] OP_FETCH_BOTH = 2'h0; // Read into instruction buffer and input register.
	localparam logic [1:0] OP_FETCH_MIR = 2'h1; // Read into input register only.
	localparam logic [1:0] OP_WRITE_WORD = 2'h2; // Write full ALU word.
	localparam logic [1:0] OP_WRITE_BYTE = 2'h3; // Write one ALU byte.
	localparam logic [1:0] SRC_OVERRIDE = 2'h0; // Upper bits: override the active cycle.
	localparam logic [1:0] SRC_ALU = 2'h1; // Address from ALU output.
	localparam logic [1:0] SRC_PC = 2'h2; // Address from program counter.
	localparam logic [1:0] SRC_MIR = 2'h3; // Address from memory input register.
	localparam logic [3:0] OPS_SPECIAL = 4'h4; // ALU output to buffers over the data bus.
	localparam logic [3:0] OPS_SUPER_RESET = 4'hA; // Reset supervisor key flag.
	localparam logic [3:0] OPS_SUPER_SET = 4'hB; // Set supervisor key flag.
	localparam logic [3:0] OPS_INT_SEL_RESET = 4'hC; // Block interrupts and clear interrupt flag.
	localparam logic [3:0] OPS_INT_SET = 4'hD; // Set interrupt flag.

	// ----------------------------------------------------------------
	// Register specifier source codes
	// ----------------------------------------------------------------
	localparam logic [1:0] RS_STORE = 2'h0; // From control store, or forced B.
	localparam logic [1:0] RS_IR_TO_B = 2'h1; // Instruction register field into B.
	localparam logic [1:0] RS_IR_TO_A = 2'h2; // Instruction register field into A.
	localparam logic [1:0] RS_HOLD = 2'h3; // Hold both fields.
	localparam logic [2:0] FORCE_B_HIGH = 3'h7; // Upper three bits of a forced B field.

	// ----------------------------------------------------------------
	// Register map, field positions and reset values
	// ----------------------------------------------------------------
	localparam logic [11:0] KEY_OFFSET = 12'h000; // Memory key register, read and write.
	localparam logic [11:0] STATUS_OFFSET = 12'h004; // Status word, read only.
	localparam int STATUS_CHANNEL_BIT = 0; // Channel flag.
	localparam int STATUS_SUPER_BIT = 1; // Supervisor key flag.
	localparam int STATUS_INT_BIT = 2; // Interrupt flag.
	localparam int STATUS_HOLD_BIT = 3; // Micro instruction held off by busy memory.
	localparam logic [3:0] KEY_RESET = 4'h0; // Key register after reset.
	localparam logic [3:0] FIELD_RESET = 4'h0; // A and B fields after reset.

endpackage

// [core/mmd_decoder.sv]
// Micro instruction decoder for memory cycles, central flags and register specifier fields.
module mmd_decoder
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Micro instruction handshake.
	input wire logic mi_valid,
	output logic mi_done,
	// Micro instruction fields.
	input wire logic [1:0] cycle_control_field,
	input wire logic [1:0] test_enable_field,
	input wire logic [3:0] condition_select_field,
	input wire logic [3:0] operation_select_field,
	input wire logic [1:0] regspec_source_field,
	input wire logic keep_msb_bit,
	input wire logic [2:0] ir_field_select,
	input wire logic [1:0] alu_b_source_field,
	input wire logic shift_control_field,
	input wire logic [1:0] misc_flag_field,
	input wire logic force_source_bit,
	input wire logic [3:0] store_a_field,
	input wire logic [3:0] store_b_field,
	input wire logic io_request,
	// Data path conditions.
	input wire logic test_result,
	input wire logic byte_address_flag,
	input wire logic [10:0] instr_reg,
	input wire logic alu_bit15,
	input wire logic operand_bit01,
	// Memory control.
	input wire logic mem_busy,
	output logic mem_start,
	output logic mem_override,
	output logic [1:0] mem_op,
	output logic [1:0] mem_addr_src,
	output logic mem_byte_right,
	output logic special_xfer,
	output logic [3:0] mem_key,
	// Flags and control buffer fields.
	output logic channel_flag,
	output logic supervisor_key_flag,
	output logic interrupt_flag,
	output logic int_block,
	output logic [3:0] a_field,
	output logic [3:0] b_field,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Picks four consecutive instruction register bits starting at the select code; the top one is zero unless keep is set.
	function automatic logic [3:0] ir_window(input logic [10:0] ir, input logic [2:0] sel, input logic keep);
		logic [10:0] shifted;
		shifted = ir >> sel;
		ir_window = {shifted[3] & keep, shifted[2:0]};
	endfunction

	// ----------------------------------------------------------------
	// Local state
	// ----------------------------------------------------------------
	logic [3:0] key_reg; // Stored memory key, kept while supervisor mode overrides it.
	logic last_was_start; // Previous accepted instruction initiated a cycle.
	logic held; // An instruction is being held off by busy memory.
	logic cycle_req; // This instruction asks for a start or override.
	logic is_override; // The request replaces the active cycle's operation.
	logic accept; // The presented instruction is taken at this edge.
	logic fields_free; // Register field control is allowed.
	logic [3:0] next_a; // Next A field.
	logic [3:0] next_b; // Next B field.
	logic apb_access; // Access phase edge on which the transfer completes.
	logic addr_known; // Address decodes to a register.

	// ----------------------------------------------------------------
	// Instruction decode
	// ----------------------------------------------------------------

	// Works out whether a memory cycle is asked for, and whether it is an override.
	always_comb
	begin
		cycle_req = 1'b0;
		unique case (cycle_control_field)
			mmd_pkg::CC_NONE:
			begin
				cycle_req = 1'b0;
			end
			mmd_pkg::CC_UNCOND:
			begin
				cycle_req = 1'b1;
			end
			mmd_pkg::CC_ON_FALSE:
			begin
				// Untested code 10 is unconditional; tested it passes on false.
				if (test_enable_field == mmd_pkg::TE_NONE)
					cycle_req = 1'b1;
				else
					cycle_req = !test_result;
			end
			mmd_pkg::CC_ON_TRUE:
			begin
				cycle_req = test_result;
			end
		endcase
		// An override code only means something right after an initiation.
		is_override = cycle_req && operation_select_field[3:2] == mmd_pkg::SRC_OVERRIDE;
		if (is_override && !last_was_start)
			cycle_req = 1'b0;
	end

	// An override rides on the busy cycle, so only fresh starts wait for memory.
	assign accept = mi_valid && !mi_done && !(cycle_req && !is_override && mem_busy);
	assign fields_free = !io_request;

	// Works out the next A and B fields of the control buffer.
	always_comb
	begin
		next_a = a_field;
		next_b = b_field;
		if (fields_free)
		begin
			if (regspec_source_field == mmd_pkg::RS_STORE)
			begin
				if (!keep_msb_bit)
				begin
					// Normal mode takes both fields straight from control store.
					next_a = store_a_field;
					next_b = store_b_field;
				end
				else
				begin
					// Forced mode: the force source bit chooses the data loop bit.
					next_b = {mmd_pkg::FORCE_B_HIGH, force_source_bit ? operand_bit01 : alu_bit15};
				end
			end
			else if (cycle_control_field == mmd_pkg::CC_NONE)
			begin
				unique case (regspec_source_field)
					mmd_pkg::RS_IR_TO_B:
					begin
						next_b = ir_window(instr_reg, ir_field_select, keep_msb_bit);
					end
					mmd_pkg::RS_IR_TO_A:
					begin
						next_a = ir_window(instr_reg, ir_field_select, keep_msb_bit);
					end
					mmd_pkg::RS_HOLD:
					begin
						// Both fields keep their values.
						next_a = a_field;
						next_b = b_field;
					end
					default:
					begin
						next_a = a_field;
						next_b = b_field;
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Handshake and sequencing
	// ----------------------------------------------------------------

	// Pulses done one cycle after an instruction is taken; the master then moves on.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			mi_done <= 1'b0;
		else
			mi_done <= accept;
	end

	// Notes a held instruction so software can see a stalled microprogram.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			held <= 1'b0;
		else
			held <= mi_valid && !mi_done && !accept;
	end

	// Remembers whether the last taken instruction initiated a cycle.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			last_was_start <= 1'b0;
		else if (accept)
			last_was_start <= cycle_req && !is_override;
	end

	// ----------------------------------------------------------------
	// Memory control outputs
	// ----------------------------------------------------------------

	// Issues starts, overrides and special transfers as one-cycle pulses.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mem_start <= 1'b0;
			mem_override <= 1'b0;
			special_xfer <= 1'b0;
		end
		else
		begin
			mem_start <= accept && cycle_req && !is_override;
			mem_override <= accept && cycle_req && is_override;
			// The special transfer uses the data bus but cycles no memory module.
			special_xfer <= accept && cycle_control_field == mmd_pkg::CC_NONE
				&& operation_select_field == mmd_pkg::OPS_SPECIAL;
		end
	end

	// Latches operation and byte lane of a started or overridden cycle, and the address source of a start only.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			mem_op <= mmd_pkg::OP_FETCH_BOTH;
			mem_addr_src <= mmd_pkg::SRC_ALU;
			mem_byte_right <= 1'b0;
		end
		else if (accept && cycle_req)
		begin
			mem_op <= operation_select_field[1:0];
			// A byte write takes the left byte on a false flag, the right on true.
			mem_byte_right <= operation_select_field[1:0] == mmd_pkg::OP_WRITE_BYTE && byte_address_flag;
			// An override keeps the address source of the cycle already running.
			if (!is_override)
				mem_addr_src <= operation_select_field[3:2];
		end
	end

	// Supervisor mode hides the stored key behind key zero without losing it.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			mem_key <= mmd_pkg::KEY_RESET;
		else
			mem_key <= supervisor_key_flag ? mmd_pkg::KEY_RESET : key_reg;
	end

	// ----------------------------------------------------------------
	// Central control flags
	// ----------------------------------------------------------------

	// Channel flag follows the condition select low bit on its own code.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			channel_flag <= 1'b0;
		else if (accept && test_enable_field == mmd_pkg::TE_NONE && cycle_control_field == mmd_pkg::CC_UNCOND)
			channel_flag <= condition_select_field[0];
	end

	// Supervisor key flag is set and reset by its two operation codes.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			supervisor_key_flag <= 1'b0;
		else if (accept && cycle_control_field == mmd_pkg::CC_NONE)
		begin
			if (operation_select_field == mmd_pkg::OPS_SUPER_SET)
				supervisor_key_flag <= 1'b1;
			else if (operation_select_field == mmd_pkg::OPS_SUPER_RESET)
				supervisor_key_flag <= 1'b0;
		end
	end

	// Interrupt flag; a set in the same instruction as a quiet clear wins.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			interrupt_flag <= 1'b0;
		else if (accept)
		begin
			if (cycle_control_field == mmd_pkg::CC_NONE && operation_select_field == mmd_pkg::OPS_INT_SET)
				interrupt_flag <= 1'b1;
			else if (cycle_control_field == mmd_pkg::CC_NONE
				&& operation_select_field == mmd_pkg::OPS_INT_SEL_RESET)
				interrupt_flag <= 1'b0;
			else if (!alu_b_source_field[1] && !shift_control_field && misc_flag_field[0])
				interrupt_flag <= 1'b0;
		end
	end

	// Blocks all interrupts for one cycle when the select-and-reset code runs.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			int_block <= 1'b0;
		else
			int_block <= accept && cycle_control_field == mmd_pkg::CC_NONE
				&& operation_select_field == mmd_pkg::OPS_INT_SEL_RESET;
	end

	// ----------------------------------------------------------------
	// Control buffer register specifier fields
	// ----------------------------------------------------------------

	// Loads the A and B fields only for instructions actually taken.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			a_field <= mmd_pkg::FIELD_RESET;
			b_field <= mmd_pkg::FIELD_RESET;
		end
		else if (accept)
		begin
			a_field <= next_a;
			b_field <= next_b;
		end
	end

	// ----------------------------------------------------------------
	// APB register slave
	// ----------------------------------------------------------------

	// The answer comes one cycle into the access phase, so every access has one wait state.
	assign apb_access = psel && penable && pready;
	assign addr_known = paddr == mmd_pkg::KEY_OFFSET || paddr == mmd_pkg::STATUS_OFFSET;

	// Raises ready for exactly one cycle per access phase.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			pready <= 1'b0;
		else
			pready <= psel && penable && !pready;
	end

	// Prepares read data and the error answer alongside ready.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (psel && penable && !pready)
		begin
			prdata <= 32'h0000_0000;
			pslverr <= !addr_known;
			if (!pwrite && paddr == mmd_pkg::KEY_OFFSET)
				prdata[3:0] <= key_reg;
			else if (!pwrite && paddr == mmd_pkg::STATUS_OFFSET)
			begin
				prdata[mmd_pkg::STATUS_CHANNEL_BIT] <= channel_flag;
				prdata[mmd_pkg::STATUS_SUPER_BIT] <= supervisor_key_flag;
				prdata[mmd_pkg::STATUS_INT_BIT] <= interrupt_flag;
				prdata[mmd_pkg::STATUS_HOLD_BIT] <= held;
			end
		end
		else
		begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// Writes the key register on the completing edge; the status word ignores writes.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			key_reg <= mmd_pkg::KEY_RESET;
		else if (apb_access && pwrite && paddr == mmd_pkg::KEY_OFFSET)
			key_reg <= pwdata[3:0];
	end

endmodule

// [verif/mmd_decoder_assertions.sv]
// Concurrent checks on the decoder's memory cycle, flag and field outputs, bound to the decoder.
module mmd_checker
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Micro instruction handshake and fields.
	input wire logic mi_valid,
	input wire logic mi_done,
	input wire logic [1:0] cycle_control_field,
	input wire logic [1:0] test_enable_field,
	input wire logic [3:0] condition_select_field,
	input wire logic [3:0] operation_select_field,
	input wire logic [1:0] regspec_source_field,
	input wire logic io_request,
	input wire logic test_result,
	input wire logic byte_address_flag,
	// Memory control.
	input wire logic mem_busy,
	input wire logic mem_start,
	input wire logic mem_override,
	input wire logic [1:0] mem_op,
	input wire logic [1:0] mem_addr_src,
	input wire logic mem_byte_right,
	input wire logic special_xfer,
	input wire logic [3:0] mem_key,
	// Flags and control buffer fields.
	input wire logic channel_flag,
	input wire logic supervisor_key_flag,
	input wire logic interrupt_flag,
	input wire logic int_block,
	input wire logic [3:0] a_field,
	input wire logic [3:0] b_field
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);
	// Short views of the two main fields.
	wire [1:0] cc = cycle_control_field;
	wire [3:0] ops = operation_select_field;
	// The cycle control field asks for a start or override in this instruction.
	wire go = cc == mmd_pkg::CC_UNCOND || (cc == mmd_pkg::CC_ON_FALSE && (test_enable_field == mmd_pkg::TE_NONE
		|| !test_result)) || (cc == mmd_pkg::CC_ON_TRUE && test_result);
	// A fresh start names an address source; upper bits 00 only override.
	wire fresh = go && ops[3:2] != mmd_pkg::SRC_OVERRIDE;
	// A waiting fresh start meets a busy memory control.
	sequence s_blocked;
		mi_valid && !mi_done && fresh && mem_busy;
	endsequence

	// ----------------------------------------
	// Memory cycle checks
	// ----------------------------------------
	AST_START: assert property (mi_done |-> mem_start == $past(fresh))
		else $error("start pulse disagrees with cycle control");
	AST_PULSE: assert property (mem_start || mem_override || special_xfer |-> mi_done)
		else $error("memory pulse outside an answered instruction");
	AST_OVERRIDE: assert property (mem_override |-> $past(go && ops[3:2] == mmd_pkg::SRC_OVERRIDE))
		else $error("override without override request");
	AST_OP: assert property (mem_start || mem_override |-> mem_op == $past(ops[1:0]))
		else $error("memory operation differs from low bits");
	AST_SOURCE: assert property (mem_start |-> mem_addr_src == $past(ops[3:2]))
		else $error("address source differs from upper bits");
	AST_BYTE: assert property (mem_start && mem_op == mmd_pkg::OP_WRITE_BYTE |-> mem_byte_right == $past(byte_address_flag))
		else $error("byte lane differs from byte address flag");
	AST_SPECIAL: assert property (mi_done |-> special_xfer == $past(cc == mmd_pkg::CC_NONE && ops == mmd_pkg::OPS_SPECIAL))
		else $error("special transfer pulse wrong");
	AST_HELD: assert property (s_blocked |=> !mi_done)
		else $error("fresh start answered while memory busy");

	// ----------------------------------------
	// Flag and field checks
	// ----------------------------------------
	AST_SUPER: assert property (mi_done && $past(cc == mmd_pkg::CC_NONE && ops == mmd_pkg::OPS_SUPER_SET) |-> supervisor_key_flag)
		else $error("supervisor flag not set");
	AST_KEY: assert property ($past(supervisor_key_flag) |-> mem_key == 4'h0)
		else $error("key not zero under supervisor flag");
	AST_CHANNEL: assert property (mi_done && $past(cc == mmd_pkg::CC_UNCOND && test_enable_field == mmd_pkg::TE_NONE)
		|-> channel_flag == $past(condition_select_field[0]))
		else $error("channel flag wrong");
	AST_BLOCK: assert property (int_block |-> mi_done && !interrupt_flag)
		else $error("interrupt block with flag still set");
	AST_FIELDS: assert property (mi_done && $past(io_request || (cc == mmd_pkg::CC_NONE
		&& regspec_source_field == mmd_pkg::RS_HOLD)) |-> $stable(a_field) && $stable(b_field))
		else $error("register fields changed while held");
endmodule

bind mmd_decoder mmd_checker mmd_checker_inst (.*);

// [verif/mmd_partner.sv]
// Model of the processor memory control that answers the decoder's cycle starts.
module mmd_partner
(
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Cycle start from the decoder and speed choice from the bench.
	input wire logic mem_start,
	input wire logic slow,
	// Busy level back to the decoder.
	output logic mem_busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] left; // Cycles left in the active memory cycle.

	// A start loads the cycle length; a slow memory keeps the next fresh start waiting.
	always_ff @(posedge clock or posedge rst)
	begin
		if (rst)
			left <= 4'h0;
		else if (mem_start)
			left <= slow ? 4'h6 : 4'h1;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
	assign mem_busy = (left != 4'h0);
endmodule

// [verif/mmd_decoder_tb.sv]
// Self-checking bench for the micro memory, flag and register field decoder.
module mmd_decoder_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Stimulus, outputs and bookkeeping
	// ----------------------------------------
	logic clock = 1'h0, rst = 1'h1, mi_valid = 1'h0, keep_msb_bit = 1'h0, shift_control_field = 1'h1;
	logic force_source_bit = 1'h0, io_request = 1'h0, test_result = 1'h0, byte_address_flag = 1'h0;
	logic alu_bit15 = 1'h0, operand_bit01 = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
	logic [1:0] cycle_control_field = 2'h0, test_enable_field = 2'h0, regspec_source_field = mmd_pkg::RS_HOLD;
	logic [1:0] alu_b_source_field = 2'h2, misc_flag_field = 2'h0;
	logic [3:0] condition_select_field = 4'h0, operation_select_field = 4'h0, store_a_field = 4'h0, store_b_field = 4'h0;
	logic [2:0] ir_field_select = 3'h0;
	logic [10:0] instr_reg = 11'h5A6; // Fixed instruction word; fields are cut from it.
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic mi_done, mem_busy, mem_start, mem_override, mem_byte_right, special_xfer, channel_flag;
	logic supervisor_key_flag, interrupt_flag, int_block, pready, pslverr, e, st, ov, sx, ib;
	logic [1:0] mem_op, mem_addr_src;
	logic [3:0] mem_key, a_field, b_field, ea, eb;
	int err_total = 0, checked = 0, waited;

	// Every bench signal carries the name of the decoder port that it meets.
	mmd_decoder mmd_decoder_inst (.*);
	mmd_partner mmd_partner_inst (.clock(clock), .rst(rst), .mem_start(mem_start), .slow(slow), .mem_busy(mem_busy));

	// Free-running 50 MHz clock.
	initial
		forever #10 clock = ~clock;

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	// Compares one value and counts the outcome.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One APB transfer; the request stands until pready is sampled high.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
		output logic er);
		int n;
		@(posedge clock);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		n = 0;
		do
			@(posedge clock);
		while (pready !== 1'h1 && ++n < 50);
		// A slave that never answers counts as a failure, not a silent pass.
		if (n >= 50)
			err_total++;
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// One micro instruction; pulses are taken at the edge that samples the answer.
	task automatic mi(input logic [1:0] cc, input logic [1:0] te, input logic [3:0] cs, input logic [3:0] op);
		@(posedge clock);
		cycle_control_field <= cc;
		test_enable_field <= te;
		condition_select_field <= cs;
		operation_select_field <= op;
		mi_valid <= 1'h1;
		waited = 0;
		do
			@(posedge clock);
		while (mi_done !== 1'h1 && ++waited < 60);
		if (waited >= 60)
			err_total++;
		st = mem_start;
		ov = mem_override;
		sx = special_xfer;
		ib = int_block;
		mi_valid <= 1'h0;
		@(negedge clock);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset values, key register and an unmapped address.
	task automatic t_reset();
		@(negedge clock);
		chk(mem_addr_src, 1, "address source");
		chk({channel_flag, supervisor_key_flag, interrupt_flag, a_field, b_field}, 0, "flags and fields");
		apb(1'h0, mmd_pkg::KEY_OFFSET, 0, q, e);
		chk(q, mmd_pkg::KEY_RESET, "key");
		apb(1'h0, 12'h008, 0, q, e);
		chk(e, 1, "unmapped error");
	endtask

	// Every operation code with each non-override source code, then every cycle control and test case.
	task automatic t_mem();
		logic g;
		for (int i = 4; i < 16; i++)
		begin
			byte_address_flag <= i[2];
			mi(mmd_pkg::CC_UNCOND, 2'h0, 4'h0, i[3:0]);
			chk({st, mem_op, mem_addr_src}, {1'h1, i[1:0], i[3:2]}, "start op source");
			if (i[1:0] == 2'h3)
				chk(mem_byte_right, i[2], "byte lane");
		end
		for (int k = 0; k < 16; k++)
		begin
			test_result <= k[0];
			mi(k[3:2], {1'h0, k[1]}, 4'h0, 4'h6);
			g = k[3:2] == 2'h1 || (k[3:2] == 2'h2 && !(k[1] && k[0])) || (k[3:2] == 2'h3 && k[0]);
			chk(st, g, "conditional start");
		end
	endtask

	// Override after a start, a second override that is ignored, a busy hold and the special transfer.
	task automatic t_seq();
		mi(mmd_pkg::CC_UNCOND, 2'h0, 4'h0, 4'hA);
		mi(mmd_pkg::CC_UNCOND, 2'h0, 4'h0, 4'h1);
		chk({st, ov, mem_op, mem_addr_src}, 6'h16, "override");
		mi(mmd_pkg::CC_UNCOND, 2'h0, 4'h0, 4'h2);
		chk({st, ov, mem_op}, 4'h1, "second override");
		slow <= 1'h1;
		mi(mmd_pkg::CC_UNCOND, 2'h0, 4'h0, 4'h6);
		mi(mmd_pkg::CC_UNCOND, 2'h0, 4'h0, 4'h6);
		chk(waited > 2, 1, "start held while busy");
		slow <= 1'h0;
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, mmd_pkg::OPS_SPECIAL);
		chk({sx, st, ov}, 3'h4, "special transfer");
	endtask

	// Channel, supervisor key and interrupt flags.
	task automatic t_flags();
		mi(mmd_pkg::CC_UNCOND, 2'h0, 4'h1, 4'h0);
		chk(channel_flag, 1, "channel set");
		mi(mmd_pkg::CC_UNCOND, 2'h1, 4'h0, 4'h0);
		chk(channel_flag, 1, "channel kept");
		mi(mmd_pkg::CC_UNCOND, 2'h0, 4'h0, 4'h0);
		chk(channel_flag, 0, "channel reset");
		apb(1'h1, mmd_pkg::KEY_OFFSET, 32'hFFFF_FFF5, q, e);
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, mmd_pkg::OPS_SUPER_SET);
		chk({supervisor_key_flag, mem_key}, 5'h10, "key zero");
		apb(1'h1, mmd_pkg::STATUS_OFFSET, 32'h0000_000F, q, e);
		apb(1'h0, mmd_pkg::STATUS_OFFSET, 0, q, e);
		chk(q, 32'h0000_0002, "status word");
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, mmd_pkg::OPS_SUPER_RESET);
		chk({supervisor_key_flag, mem_key}, 5'h05, "key back");
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, mmd_pkg::OPS_INT_SET);
		chk(interrupt_flag, 1, "interrupt set");
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, mmd_pkg::OPS_INT_SEL_RESET);
		chk({ib, interrupt_flag}, 2'h2, "select and reset");
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, mmd_pkg::OPS_INT_SET);
		alu_b_source_field <= 2'h0;
		shift_control_field <= 1'h0;
		misc_flag_field <= 2'h1;
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, 4'h0);
		chk({ib, interrupt_flag}, 2'h0, "quiet clear");
		alu_b_source_field <= 2'h2;
		shift_control_field <= 1'h1;
		misc_flag_field <= 2'h0;
	endtask

	// Copy, field extraction with masking, hold, forced B and I/O suppression.
	task automatic t_fields();
		store_a_field <= 4'h3;
		store_b_field <= 4'h9;
		regspec_source_field <= mmd_pkg::RS_STORE;
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, 4'h0);
		chk({a_field, b_field}, 8'h39, "copy");
		regspec_source_field <= mmd_pkg::RS_IR_TO_B;
		for (int s = 0; s < 8; s++)
		begin
			ir_field_select <= s[2:0];
			keep_msb_bit <= s[0];
			mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, 4'h0);
			eb = instr_reg[s +: 4];
			eb[3] = eb[3] & s[0];
			chk({a_field, b_field}, {4'h3, eb}, "field into B");
		end
		ir_field_select <= 3'h6;
		regspec_source_field <= mmd_pkg::RS_IR_TO_A;
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, 4'h0);
		ea = instr_reg[9:6];
		chk({a_field, b_field}, {ea, eb}, "field into A");
		store_a_field <= 4'hC;
		store_b_field <= 4'hD;
		regspec_source_field <= mmd_pkg::RS_HOLD;
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, 4'h0);
		chk({a_field, b_field}, {ea, eb}, "hold");
		regspec_source_field <= mmd_pkg::RS_STORE;
		force_source_bit <= 1'h1;
		operand_bit01 <= 1'h1;
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, 4'h0);
		chk({a_field, b_field}, {ea, 4'hF}, "forced from operand");
		force_source_bit <= 1'h0;
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, 4'h0);
		chk({a_field, b_field}, {ea, 4'hE}, "forced from ALU");
		keep_msb_bit <= 1'h0;
		io_request <= 1'h1;
		mi(mmd_pkg::CC_NONE, 2'h0, 4'h0, 4'h0);
		chk({a_field, b_field}, {ea, 4'hE}, "I/O suppression");
		io_request <= 1'h0;
	endtask

	// Prints the verdict and ends the run.
	task automatic summarize();
		if (err_total == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Main sequence: reset for four cycles, then the scenarios.
	initial
	begin
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		t_reset();
		t_mem();
		t_seq();
		t_flags();
		t_fields();
		summarize();
	end

	// Watchdog: the run needs well under 2000 cycles, so 20000 means a hang.
	initial
	begin
		#400000;
		err_total++;
		summarize();
	end
endmodule
